// File: hw/pie_irq_map.vh
// Constants for the low-group peripheral interrupt expander.
`ifndef PIE_IRQ_MAP_VH
`define PIE_IRQ_MAP_VH
`define PIE_NUM_SRC        17
`define PIE_CODE_W         16
`define PIE_ADCINT_CODE    16'h0004
`define PIE_CODE_T2P       16'h002b
`define PIE_CODE_T2C       16'h002c
`define PIE_CODE_T2UF      16'h002d
`define PIE_CODE_T2OF      16'h002e
`define PIE_CODE_T4P       16'h0039
`define PIE_CODE_T4C       16'h003a
`define PIE_CODE_T4UF      16'h003b
`define PIE_CODE_T4OF      16'h003c
`define PIE_CODE_SPI       16'h0005
`define PIE_CODE_SRX       16'h0006
`define PIE_CODE_STX       16'h0007
`define PIE_CODE_CANMB     16'h0040
`define PIE_CODE_CANER     16'h0041
`define PIE_CODE_XP1       16'h0001
`define PIE_CODE_XP2       16'h0011
`define PIE_CODE_NONE      16'h0000
`define PIE_VEC_LINE1      16'h0002
`define PIE_VEC_LINE3      16'h0006
`define PIE_VEC_LINE5      16'h000a
`define PIE_VEC_LINE6      16'h000c
`define PIE_LINE_NONE      2'd0
`define PIE_LINE_ONE       2'd1
`define PIE_LINE_LOW       2'd2
`endif

// File: hw/pie_irq_low.v
// Peripheral interrupt expander for the low-priority core request lines.
// Function
// - Timer-2 requests to line three, priority 28-31.
// - Timer-4 requests to line three, priority 32-35.
// - Serial periph request to line five, 42.
// - Serial receive request to line five, 43.
// - Serial transmit request to line five, 44.
// - CAN mailbox request to line five, 45.
// - CAN error request to line five, 46.
// - External pin requests to line six, 48-49.
// - High-priority mode moves source to line one.
`timescale 1ns/1ns
`include "pie_irq_map.vh"
`default_nettype none
module pie_irq_low
#(
  parameter NUM_SRC = `PIE_NUM_SRC,
  parameter CODE_W  = `PIE_CODE_W
)
(
  input  wire                 clock_in,
  input  wire                 rst_n_in,
  input  wire [3:0]           timer_two_request_in,
  input  wire [3:0]           timer_four_request_in,
  input  wire                 serial_periph_request_in,
  input  wire                 serial_receive_request_in,
  input  wire                 serial_transmit_request_in,
  input  wire                 can_mailbox_request_in,
  input  wire                 can_error_request_in,
  input  wire                 adc_request_in,
  input  wire                 external_pin_request_one_in,
  input  wire                 external_pin_request_two_in,
  input  wire [7:0]           high_priority_mode_in,
  input  wire [3:0]           acknowledge_line_in,
  output wire [NUM_SRC-1:0]   pending_request_set_out,
  output wire                 core_line_one_out,
  output wire                 core_line_three_out,
  output wire                 core_line_five_out,
  output wire                 core_line_six_out,
  output reg  [CODE_W-1:0]    source_identification_code_out,
  output reg  [CODE_W-1:0]    core_vector_out
);
  // Every request is edge detected: a level held high raises its pending bit
  // once, and the source must drop and rise again to be counted a second time.
  // Repeat edges while a bit is still pending simply merge into it.

  // Source index order equals overall priority order while no mode bit is set; index 0 is highest.
  // 0-3 timer 2, 4-7 timer 4, 8 spi, 9 rx, 10 tx, 11 canmb, 12 caner,
  // 13 adc, 14 pin one, 15 pin two. Bit 16 is spare and never set.
  // The two pin requests arrive from the external interrupt logic, which
  // already runs on this clock, so they take no synchroniser here; a raw
  // pin wired straight to them would need one in front of this block.
  // Unused indices return the no-source code.
  function [CODE_W-1:0] src_code;
    input integer idx;
    begin
      case (idx)
        0:  src_code = `PIE_CODE_T2P;
        1:  src_code = `PIE_CODE_T2C;
        2:  src_code = `PIE_CODE_T2UF;
        3:  src_code = `PIE_CODE_T2OF;
        4:  src_code = `PIE_CODE_T4P;
        5:  src_code = `PIE_CODE_T4C;
        6:  src_code = `PIE_CODE_T4UF;
        7:  src_code = `PIE_CODE_T4OF;
        8:  src_code = `PIE_CODE_SPI;
        9:  src_code = `PIE_CODE_SRX;
        10: src_code = `PIE_CODE_STX;
        11: src_code = `PIE_CODE_CANMB;
        12: src_code = `PIE_CODE_CANER;
        13: src_code = `PIE_ADCINT_CODE;
        14: src_code = `PIE_CODE_XP1;
        15: src_code = `PIE_CODE_XP2;
        default: src_code = `PIE_CODE_NONE;
      endcase
    end
  endfunction

  // Core line selected by a source: 0 line1, 1 line3, 2 line5, 3 line6.
  // Timer sources have no mode bit and always stay on line three.
  function [1:0] src_line;
    input integer idx;
    input [7:0]   hp;
    begin
      if (idx < 8)
        src_line = 2'd1;
      else if (idx < 14)
        src_line = hp[idx-8] ? 2'd0 : 2'd2;
      else if (idx < 16)
        src_line = hp[idx-8] ? 2'd0 : 2'd3;
      else
        src_line = 2'd2;
    end
  endfunction

  // Request vector in index order; the spare top bit is tied low.
  wire [NUM_SRC-1:0] raw_req;
  assign raw_req = {1'b0, external_pin_request_two_in, external_pin_request_one_in,
                    adc_request_in, can_error_request_in, can_mailbox_request_in,
                    serial_transmit_request_in, serial_receive_request_in,
                    serial_periph_request_in, timer_four_request_in,
                    timer_two_request_in};

  // Pending state, request history and per-line winner bookkeeping.
  reg  [NUM_SRC-1:0] pend_q;
  reg  [NUM_SRC-1:0] req_d1_q;
  reg  [NUM_SRC-1:0] pend_d;
  reg  [4:0]         win_idx [0:3];
  reg  [3:0]         win_ok;
  reg  [3:0]         ack_d1_q;
  wire [NUM_SRC-1:0] rise = raw_req & ~req_d1_q;
  wire [3:0]         ack_pulse = acknowledge_line_in & ~ack_d1_q;
  integer i;
  integer l;
  wire [NUM_SRC-1:0] clr_mask [0:3];
  wire [NUM_SRC-1:0] clr_all;
  genvar             g;

  // Per-line winner: lowest index pending on each line.
  // Scanning downwards lets the lowest index overwrite any higher one.
  always @*
  begin
    for (l = 0; l < 4; l = l + 1)
    begin
      win_idx[l] = 5'd0;
      win_ok[l] = 1'b0;
    end
    for (i = NUM_SRC - 1; i >= 0; i = i - 1)
    begin
      if (pend_q[i])
      begin
        win_idx[src_line(i, high_priority_mode_in)] = i[4:0];
        win_ok[src_line(i, high_priority_mode_in)] = 1'b1;
      end
    end
  end

  // One clear mask per core line. An acknowledge edge on a line with nothing
  // pending leaves every bit alone, so a stray acknowledge is harmless.
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_clear
      assign clr_mask[g] = (ack_pulse[g] && win_ok[g]) ?
                           ({{(NUM_SRC-1){1'b0}}, 1'b1} << win_idx[g]) :
                           {NUM_SRC{1'b0}};
    end
  endgenerate

  // Clears from all four lines merge; each line removes at most one source.
  assign clr_all = clr_mask[0] | clr_mask[1] | clr_mask[2] | clr_mask[3];

  // Pending update. A new edge in the acknowledge cycle wins over the clear,
  // so a source that fires again just as it is served is never lost.
  always @*
  begin
    pend_d = (pend_q & ~clr_all) | rise;
    pend_d[NUM_SRC-1] = 1'b0;
  end

  // State registers. The request history clears on reset, so a request that
  // is already high when reset lifts counts as a fresh edge at the first clock.
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pend_q   <= {NUM_SRC{1'b0}};
      req_d1_q <= {NUM_SRC{1'b0}};
      ack_d1_q <= 4'h0;
    end
    else
    begin
      pend_q   <= pend_d;
      req_d1_q <= raw_req;
      ack_d1_q <= acknowledge_line_in;
    end
  end

  // Code and vector for the highest-priority active line, registered.
  // Registering costs one cycle after the line output rises, but the core
  // then reads a code that cannot glitch while the pending set changes.
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      source_identification_code_out <= `PIE_CODE_NONE;
      core_vector_out <= `PIE_CODE_NONE;
    end
    else if (win_ok[0])
    begin
      source_identification_code_out <= src_code(win_idx[0]);
      core_vector_out <= `PIE_VEC_LINE1;
    end
    else if (win_ok[1])
    begin
      source_identification_code_out <= src_code(win_idx[1]);
      core_vector_out <= `PIE_VEC_LINE3;
    end
    else if (win_ok[2])
    begin
      source_identification_code_out <= src_code(win_idx[2]);
      core_vector_out <= `PIE_VEC_LINE5;
    end
    else if (win_ok[3])
    begin
      source_identification_code_out <= src_code(win_idx[3]);
      core_vector_out <= `PIE_VEC_LINE6;
    end
    else
    begin
      source_identification_code_out <= `PIE_CODE_NONE;
      core_vector_out <= `PIE_CODE_NONE;
    end
  end

  // The line outputs are combinational so a mode change reroutes at once.
  assign pending_request_set_out = pend_q;
  assign core_line_one_out   = win_ok[0];
  assign core_line_three_out = win_ok[1];
  assign core_line_five_out  = win_ok[2];
  assign core_line_six_out   = win_ok[3];
endmodule
`default_nettype wire

// File: dv/pie_irq_low_properties.sv
// Concurrent checks on the low-group interrupt expander ports.
`timescale 1ns/1ns
`default_nettype none
module pie_irq_low_props
(
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic [3:0]  timer_two_request_in,
  input wire logic [7:0]  high_priority_mode_in,
  input wire logic [3:0]  acknowledge_line_in,
  input wire logic [16:0] pending_request_set_out,
  input wire logic        core_line_three_out,
  input wire logic [15:0] source_identification_code_out,
  input wire logic [15:0] core_vector_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // A lone pending source shows its code and line vector one cycle later.
  property p_one(p, m, c, v);
    pending_request_set_out == p && !m |=>
      source_identification_code_out == c && core_vector_out == v;
  endproperty
  // An acknowledge edge on line three with only one timer request pending.
  sequence s_ack;
    $rose(acknowledge_line_in[1]) && pending_request_set_out == 17'h1;
  endsequence
  a_t2_rise: assert property ($rose(timer_two_request_in[0]) |=>
    pending_request_set_out[0] && core_line_three_out) else $error("t2 rise");
  a_t4_code: assert property (p_one(17'h10, 1'b0, 16'h0039, 16'h0006))
    else $error("t4 code");
  a_spi_code: assert property (p_one(17'h100, high_priority_mode_in[0], 16'h0005, 16'h000a))
    else $error("spi code");
  a_rx_code: assert property (p_one(17'h200, high_priority_mode_in[1], 16'h0006, 16'h000a))
    else $error("rx code");
  a_caner_code: assert property (p_one(17'h1000, high_priority_mode_in[4], 16'h0041, 16'h000a))
    else $error("caner code");
  a_xp_one_code: assert property (p_one(17'h4000, high_priority_mode_in[6], 16'h0001, 16'h000c))
    else $error("xp1 code");
  a_hp_line_one: assert property (p_one(17'h100, !high_priority_mode_in[0], 16'h0005, 16'h0002))
    else $error("line one");
  a_ack_clears: assert property (s_ack |=> pending_request_set_out == 17'h0)
    else $error("ack clear");
endmodule
`default_nettype wire

// File: dv/pie_core_model.sv
// Behavioural core that acknowledges its highest active request line.
`timescale 1ns/1ns
`default_nettype none
module pie_core_model
(
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic       take_in,
  input  wire logic [3:0] line_in,
  output var  logic [3:0] ack_out
);
  // Pulses last one cycle so that each acknowledge is a fresh edge.
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      ack_out <= 4'h0;
    else if (ack_out != 4'h0 || !take_in)
      ack_out <= 4'h0;
    else
      ack_out <= line_in & (~line_in + 4'h1);
  end
endmodule
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the low-group interrupt expander.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module tb;
  logic        clk = 0;
  logic        rst_n = 0;
  logic        take = 0;
  logic [15:0] req = 0;
  logic [7:0]  hp = 0;
  logic [3:0]  ack, ln;
  logic [16:0] pend;
  logic [15:0] code, vec;
  int          bad_count = 0;
  int          checked = 0;
  logic [15:0] ct [16] = '{16'h2b, 16'h2c, 16'h2d, 16'h2e, 16'h39, 16'h3a, 16'h3b, 16'h3c,
                           16'h05, 16'h06, 16'h07, 16'h40, 16'h41, 16'h04, 16'h01, 16'h11};
  always #10 clk = ~clk;
  pie_irq_low DUT (.clock_in(clk), .rst_n_in(rst_n),
    .timer_two_request_in(req[3:0]), .timer_four_request_in(req[7:4]),
    .serial_periph_request_in(req[8]), .serial_receive_request_in(req[9]),
    .serial_transmit_request_in(req[10]), .can_mailbox_request_in(req[11]),
    .can_error_request_in(req[12]), .adc_request_in(req[13]),
    .external_pin_request_one_in(req[14]), .external_pin_request_two_in(req[15]),
    .high_priority_mode_in(hp), .acknowledge_line_in(ack), .pending_request_set_out(pend),
    .core_line_one_out(ln[0]), .core_line_three_out(ln[1]), .core_line_five_out(ln[2]),
    .core_line_six_out(ln[3]), .source_identification_code_out(code), .core_vector_out(vec));
  pie_core_model core (.clock_in(clk), .rst_n_in(rst_n), .take_in(take), .line_in(ln),
    .ack_out(ack));
  task report_and_stop;
    $display("checks %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // The core acknowledges until nothing is pending; a stuck bit ends the run.
  task drain;
    take = 1;
    for (int n = 0; n < 60 && pend !== 17'h0; n++)
      @(negedge clk);
    take = 0;
    if (pend !== 17'h0)
    begin
      bad_count++;
      report_and_stop;
    end
    @(negedge clk);
    `CHK("idle code", 16'h0, code)
    `CHK("idle vec", 16'h0, vec)
  endtask
  // Pulse one source, then judge its code and vector once they have settled.
  task one_src(input int i, input logic hpo);
    @(negedge clk) req[i] = 1'b1;
    @(negedge clk) req[i] = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("code", ct[i], code)
    `CHK("vec", hpo && i > 7 ? 16'h2 : i < 8 ? 16'h6 : i < 14 ? 16'ha : 16'hc, vec)
    `CHK("line", hpo && i > 7 ? 4'h1 : i < 8 ? 4'h2 : i < 14 ? 4'h4 : 4'h8, ln)
    `CHK("pend", 17'h1 << i, pend)
    drain;
  endtask
  task t_low;
    for (int i = 0; i < 16; i++)
      one_src(i, 1'b0);
    $display("low mode done");
  endtask
  task t_high;
    hp = 8'hff;
    for (int i = 8; i < 16; i++)
      one_src(i, 1'b1);
    hp = 8'h00;
    $display("high mode done");
  endtask
  // Three sources at once; a single acknowledge must remove only the winner.
  task t_prio;
    @(negedge clk) req = 16'h8300;
    @(negedge clk) req = 16'h0;
    repeat (2) @(negedge clk);
    `CHK("first", 16'h0005, code)
    take = 1;
    @(negedge clk) take = 0;
    repeat (3) @(negedge clk);
    `CHK("second", 16'h0006, code)
    `CHK("left", 17'h8200, pend)
    drain;
    $display("priority done");
  endtask
  initial
  begin
    repeat (6) @(negedge clk);
    rst_n = 1;
    t_low;
    t_high;
    t_prio;
    report_and_stop;
  end
endmodule
bind pie_irq_low pie_irq_low_props chk (
  .clock_in                       (clock_in),
  .rst_n_in                       (rst_n_in),
  .timer_two_request_in           (timer_two_request_in),
  .high_priority_mode_in          (high_priority_mode_in),
  .acknowledge_line_in            (acknowledge_line_in),
  .pending_request_set_out        (pending_request_set_out),
  .core_line_three_out            (core_line_three_out),
  .source_identification_code_out (source_identification_code_out),
  .core_vector_out                (core_vector_out)
);
`default_nettype wire
